// [src/cbd_drain_lock.sv]
`timescale 1ns/1ps
module cbd_drain_lock (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control register move from core and debug unit
    input wire logic core_ctrl_wr,
    input wire logic dbg_ctrl_wr,
    input wire logic dbg_ctrl_rd,
    input wire logic [11:0] ctrl_index,
    input wire logic [31:0] ctrl_wdata,
    output logic [31:0] dbg_ctrl_rdata,
    // decoded control
    output logic cache_on,
    output logic store_buf_on,
    output logic push_keeps_valid,
    output logic half_lock,
    // core write request
    input wire logic wr_req,
    input wire logic wr_imprecise,
    input wire logic wr_inhibited,
    input wire logic [31:0] wr_addr,
    input wire logic [31:0] wr_data,
    output logic wr_stall,
    // fill, sync, push
    input wire logic fill_req,
    input wire logic sync_req,
    input wire logic push_load,
    input wire logic [31:0] push_addr,
    output logic fill_stall,
    output logic sync_stall,
    output logic push_busy,
    // allocation and state
    input wire logic alloc_req,
    input wire logic [3:0] set_valid,
    input wire logic hit_write,
    input wire logic hit_copyback,
    input wire logic line_push_instr,
    input wire logic line_modified,
    output logic [1:0] victim_way,
    output logic alloc_ok,
    output logic set_modified,
    output logic push_writeback,
    output logic push_invalidate,
    output logic inv_busy,
    output logic inv_clear,
    output logic [6:0] inv_set,
    // external bus
    input wire logic bus_free,
    input wire logic bus_done,
    output logic bus_req,
    output cbd_pkg::cbd_bus_kind_t bus_kind,
    output logic [31:0] bus_addr,
    output logic [31:0] bus_data
);
    // ****************************************
    // control register
    // ****************************************
    logic [31:0] ctrl_q, ctrl_d;
    logic ctrl_hit, ctrl_wr, inv_start, inv_done;
    logic [6:0] inv_set_q;
    logic inv_busy_q;
    assign ctrl_hit = (ctrl_index == cbd_pkg::CTRL_INDEX);
    assign ctrl_wr = ctrl_hit && (core_ctrl_wr || dbg_ctrl_wr);
    assign inv_start = ctrl_wr && ctrl_wdata[cbd_pkg::INV_ALL_BIT];
    assign inv_done = inv_busy_q && (inv_set_q == cbd_pkg::LAST_SET);
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d = ctrl_wdata & cbd_pkg::CTRL_WMASK;
        end
        if (inv_done && !inv_start) begin
            ctrl_d[cbd_pkg::INV_ALL_BIT] = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= cbd_pkg::CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dbg_ctrl_rdata <= 32'h00000000;
        end else if (dbg_ctrl_rd && ctrl_hit) begin
            dbg_ctrl_rdata <= ctrl_q;
        end
    end
    assign cache_on = ctrl_q[cbd_pkg::CACHE_ON_BIT];
    assign store_buf_on = ctrl_q[cbd_pkg::STORE_BUF_ON_BIT];
    assign push_keeps_valid = ctrl_q[cbd_pkg::PUSH_KEEPS_VALID_BIT];
    assign half_lock = ctrl_q[cbd_pkg::HALF_LOCK_BIT];

    // ****************************************
    // invalidate all sequencer
    // ****************************************
    // walk every set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inv_busy_q <= 1'b0;
            inv_set_q <= 7'h00;
        end else if (inv_start) begin
            inv_busy_q <= 1'b1;
            inv_set_q <= 7'h00;
        end else if (inv_busy_q) begin
            inv_busy_q <= !inv_done;
            inv_set_q <= inv_set_q + 7'h01;
        end
    end
    assign inv_busy = inv_busy_q;
    assign inv_clear = inv_busy_q;
    assign inv_set = inv_set_q;

    // ****************************************
    // store buffer
    // ****************************************
    logic [2:0] sb_cnt_q;
    logic [1:0] sb_wp_q, sb_rp_q;
    logic sb_full, sb_empty, sb_push, sb_pop, sb_use, direct_wr;
    logic [63:0] sb_rdata;
    logic push_valid_q;
    logic [31:0] push_addr_q;
    logic buffers_empty;
    assign sb_full = (sb_cnt_q == 3'(cbd_pkg::SB_DEPTH));
    assign sb_empty = (sb_cnt_q == 3'h0);
    // buffer only imprecise writes when enabled
    assign sb_use = store_buf_on && wr_imprecise;
    assign sb_push = wr_req && sb_use && !sb_full;
    assign direct_wr = wr_req && !sb_use;

    cbd_sb_mem u_sb_mem (
        .clk(clk),
        .wr_en(sb_push),
        .wr_idx(sb_wp_q),
        .wr_data({wr_addr, wr_data}),
        .rd_idx(sb_rp_q),
        .rd_data(sb_rdata)
    );

    // ****************************************
    // bus arbiter
    // ****************************************
    logic busy_q;
    cbd_pkg::cbd_bus_kind_t kind_q;
    logic [31:0] addr_q, data_q;
    logic sb_rd_ok_q;
    assign buffers_empty = sb_empty && !push_valid_q;
    // pop one entry per completed store cycle
    assign sb_pop = busy_q && bus_done && (kind_q == cbd_pkg::BUS_STORE);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sb_cnt_q <= 3'h0;
            sb_wp_q <= 2'h0;
            sb_rp_q <= 2'h0;
        end else begin
            sb_cnt_q <= sb_cnt_q + 3'(sb_push) - 3'(sb_pop);
            sb_wp_q <= sb_wp_q + 2'(sb_push);
            sb_rp_q <= sb_rp_q + 2'(sb_pop);
        end
    end
    // read data valid one cycle after pointer settles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sb_rd_ok_q <= 1'b0;
        end else begin
            sb_rd_ok_q <= !sb_empty && !sb_pop && !sb_push;
        end
    end
    // push buffer holds a displaced modified line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            push_valid_q <= 1'b0;
            push_addr_q <= 32'h00000000;
        end else if (push_load) begin
            push_valid_q <= 1'b1;
            push_addr_q <= push_addr;
        end else if (busy_q && bus_done && kind_q == cbd_pkg::BUS_PUSH) begin
            push_valid_q <= 1'b0;
        end
    end
    // start next cycle: push, stores in order, then fill
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            kind_q <= cbd_pkg::BUS_NONE;
            addr_q <= 32'h00000000;
            data_q <= 32'h00000000;
        end else if (busy_q) begin
            if (bus_done) begin
                busy_q <= 1'b0;
                kind_q <= cbd_pkg::BUS_NONE;
            end
        end else if (bus_free) begin
            if (push_valid_q) begin
                busy_q <= 1'b1;
                kind_q <= cbd_pkg::BUS_PUSH;
                addr_q <= push_addr_q;
            end else if (sb_rd_ok_q && !sb_empty) begin
                busy_q <= 1'b1;
                kind_q <= cbd_pkg::BUS_STORE;
                addr_q <= sb_rdata[63:32];
                data_q <= sb_rdata[31:0];
            end else if (fill_req && buffers_empty && !inv_busy_q) begin
                busy_q <= 1'b1;
                kind_q <= cbd_pkg::BUS_FILL;
            end
        end
    end
    assign bus_req = busy_q;
    assign bus_kind = kind_q;
    assign bus_addr = addr_q;
    assign bus_data = data_q;
    assign push_busy = push_valid_q;

    // ****************************************
    // stalls
    // ****************************************
    // fill waits for drain
    assign fill_stall = fill_req && (!buffers_empty || inv_busy_q);
    // synchronising events wait for empty buffers
    assign sync_stall = sync_req && !buffers_empty;
    // full buffer or direct write holds pipeline; invalidate stalls access
    assign wr_stall = wr_req && ((sb_use && sb_full) || direct_wr || inv_busy_q);

    // ****************************************
    // allocation
    // ****************************************
    logic [1:0] rr_q, rr_d, low_inv, lock_pick;
    logic all_valid, lock_full;
    assign low_inv = !set_valid[0] ? 2'd0 : !set_valid[1] ? 2'd1 :
                     !set_valid[2] ? 2'd2 : 2'd3;
    assign all_valid = &set_valid;
    assign lock_full = set_valid[2] && set_valid[3];
    // locked choice among ways two and three
    assign lock_pick = !set_valid[2] ? 2'd2 : !set_valid[3] ? 2'd3 :
                       (rr_q[1] ? 2'd3 : 2'd2);
    // never ways zero or one under lock
    assign victim_way = half_lock ? lock_pick : (all_valid ? rr_q : low_inv);
    assign alloc_ok = alloc_req && cache_on && !inv_busy_q;
    always_comb begin
        rr_d = rr_q;
        if (alloc_ok && half_lock && lock_full) begin
            rr_d = rr_q ^ 2'h2; // modulo two step
        end else if (alloc_ok && !half_lock && all_valid) begin
            rr_d = rr_q + 2'h1; // modulo four step
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rr_q <= 2'h0;
        end else begin
            rr_q <= rr_d;
        end
    end
    // write hits update any way, copyback marks modified
    assign set_modified = cache_on && hit_write && hit_copyback;
    assign push_writeback = line_push_instr && line_modified;
    assign push_invalidate = line_push_instr && !push_keeps_valid;

    // ****************************************
    // checks
    // ****************************************
    a_lock_victim: assert property (@(posedge clk) disable iff (!rst_n)
        half_lock |-> victim_way[1]) else $error("locked way chosen");
    a_way2_first: assert property (@(posedge clk) disable iff (!rst_n)
        half_lock && !set_valid[2] |-> victim_way == 2'd2) else $error("way2 not first");
    a_low_invalid: assert property (@(posedge clk) disable iff (!rst_n)
        !half_lock && !set_valid[0] |-> victim_way == 2'd0) else $error("not lowest");
    a_fill_wait: assert property (@(posedge clk) disable iff (!rst_n)
        !busy_q && bus_free && fill_req && !buffers_empty |=> kind_q != cbd_pkg::BUS_FILL)
        else $error("fill before drain");
    a_sync_hold: assert property (@(posedge clk) disable iff (!rst_n)
        sync_req && push_valid_q |-> sync_stall) else $error("sync not held");
    a_reset_off: assert property (@(posedge clk) $rose(rst_n) |-> !cache_on)
        else $error("cache on after reset");
    a_resv_zero: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_q[30]) else $error("reserved bit set");
    // walk busy for sets 0..127, then drops one edge later
    a_inv_clears: assert property (@(posedge clk) disable iff (!rst_n)
        inv_start |-> ##128 inv_busy_q ##1 !inv_busy_q) else $error("invalidate length wrong");
    a_precise_bypass: assert property (@(posedge clk) disable iff (!rst_n)
        wr_req && wr_inhibited && !wr_imprecise |-> !sb_push) else $error("precise buffered");
    a_push_first: assert property (@(posedge clk) disable iff (!rst_n)
        !busy_q && bus_free && push_valid_q |=> kind_q == cbd_pkg::BUS_PUSH)
        else $error("push not issued");
    c_store_drain: cover property (@(posedge clk) disable iff (!rst_n) sb_pop);
    c_fill_go: cover property (@(posedge clk) disable iff (!rst_n) kind_q == cbd_pkg::BUS_FILL);
    c_inv_end: cover property (@(posedge clk) disable iff (!rst_n) inv_done);
    c_sb_full: cover property (@(posedge clk) disable iff (!rst_n) sb_full);
endmodule // cbd_drain_lock

// [inc/cbd_pkg.sv]
package cbd_pkg;
    // ****************************************
    // cache control register
    // ****************************************
    localparam logic [11:0] CTRL_INDEX = 12'h002; // control register number
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam int CACHE_ON_BIT = 31;
    localparam int STORE_BUF_ON_BIT = 29;
    localparam int PUSH_KEEPS_VALID_BIT = 28;
    localparam int HALF_LOCK_BIT = 27;
    localparam int INV_ALL_BIT = 24;
    // writable bits: 31, 29, 28, 27, 24
    localparam logic [31:0] CTRL_WMASK = 32'hB9000000;

    // ****************************************
    // geometry
    // ****************************************
    localparam int WAYS = 4;
    localparam int SET_W = 7;
    localparam int SETS = 128;
    localparam int SB_DEPTH = 4;
    localparam int SB_PTR_W = 2;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam logic [SET_W-1:0] LAST_SET = 7'h7F;

    // ****************************************
    // external bus request kinds
    // ****************************************
    typedef enum logic [1:0] {
        BUS_NONE,
        BUS_PUSH,
        BUS_STORE,
        BUS_FILL
    } cbd_bus_kind_t;
endpackage

// [src/cbd_sb_mem.sv]
`timescale 1ns/1ps
// store buffer entry storage, registered read data
module cbd_sb_mem (
    // clock
    input wire logic clk,
    // write port
    input wire logic wr_en,
    input wire logic [cbd_pkg::SB_PTR_W-1:0] wr_idx,
    input wire logic [cbd_pkg::ADDR_W+cbd_pkg::DATA_W-1:0] wr_data,
    // read port
    input wire logic [cbd_pkg::SB_PTR_W-1:0] rd_idx,
    output logic [cbd_pkg::ADDR_W+cbd_pkg::DATA_W-1:0] rd_data
);
    logic [cbd_pkg::ADDR_W+cbd_pkg::DATA_W-1:0] mem_q [cbd_pkg::SB_DEPTH];

    // write and registered read
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
        end
        rd_data <= mem_q[rd_idx];
    end
endmodule // cbd_sb_mem

// [dv/cbd_bus_model.sv]
`timescale 1ns/1ps
// ****************************************
// external bus controller partner
// ****************************************
module cbd_bus_model #(
    parameter int LAT = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bus from block
    input wire logic bus_req,
    input wire cbd_pkg::cbd_bus_kind_t bus_kind,
    input wire logic [31:0] bus_addr,
    input wire logic [31:0] bus_data,
    // bench hold-off
    input wire logic stall,
    // bus answers
    output logic bus_free,
    output logic bus_done,
    // last finished cycle
    output cbd_pkg::cbd_bus_kind_t got_kind,
    output logic [31:0] got_addr,
    output logic [31:0] got_data,
    output int got_cnt
);
    int wait_q;
    // busy while a cycle runs or while held off
    assign bus_free = !stall && !bus_req;
    // end each cycle after LAT waiting cycles
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_done <= 1'b0;
            wait_q <= 0;
        end else begin
            bus_done <= 1'b0;
            if (bus_req && !bus_done) begin
                wait_q <= (wait_q == LAT) ? 0 : wait_q + 1;
                bus_done <= (wait_q == LAT);
            end
        end
    end
    // record each finished cycle for the bench
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            got_cnt <= 0;
        end else if (bus_req && bus_done) begin
            got_kind <= bus_kind;
            got_addr <= bus_addr;
            got_data <= bus_data;
            got_cnt <= got_cnt + 1;
        end
    end
endmodule // cbd_bus_model

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_n, core_ctrl_wr, dbg_ctrl_wr, dbg_ctrl_rd, stall;
    logic [11:0] ctrl_index;
    logic [31:0] ctrl_wdata, dbg_ctrl_rdata, wr_addr, wr_data, push_addr, bus_addr, bus_data;
    logic cache_on, store_buf_on, push_keeps_valid, half_lock, wr_req, wr_imprecise;
    logic wr_inhibited, wr_stall, fill_req, sync_req, push_load, fill_stall, sync_stall;
    logic push_busy, alloc_req, hit_write, hit_copyback, line_push_instr, line_modified;
    logic alloc_ok, set_modified, push_writeback, push_invalidate, inv_busy, inv_clear;
    logic bus_free, bus_done, bus_req;
    logic [3:0] set_valid;
    logic [1:0] victim_way;
    logic [6:0] inv_set, last;
    cbd_pkg::cbd_bus_kind_t bus_kind, got_kind;
    logic [31:0] got_addr, got_data;
    int got_cnt, miscompares, cmp_count, n;
    // victim table: unlocked rows 0..9, locked rows 10..16
    logic [3:0] vv [17] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hB, 4'hE, 4'hF, 4'hF, 4'hF, 4'hF,
        4'h0, 4'h3, 4'h7, 4'hB, 4'hD, 4'hF, 4'hC};
    logic [1:0] ve [17] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3,
        2'h2, 2'h2, 2'h3, 2'h2, 2'h2, 2'h3, 2'h2};

    cbd_drain_lock u_dut (.clk, .rst_n, .core_ctrl_wr, .dbg_ctrl_wr, .dbg_ctrl_rd,
        .ctrl_index, .ctrl_wdata, .dbg_ctrl_rdata, .cache_on, .store_buf_on,
        .push_keeps_valid, .half_lock, .wr_req, .wr_imprecise, .wr_inhibited, .wr_addr,
        .wr_data, .wr_stall, .fill_req, .sync_req, .push_load, .push_addr, .fill_stall,
        .sync_stall, .push_busy, .alloc_req, .set_valid, .hit_write, .hit_copyback,
        .line_push_instr, .line_modified, .victim_way, .alloc_ok, .set_modified,
        .push_writeback, .push_invalidate, .inv_busy, .inv_clear, .inv_set, .bus_free,
        .bus_done, .bus_req, .bus_kind, .bus_addr, .bus_data);
    cbd_bus_model u_bus (.clk, .rst_n, .bus_req, .bus_kind, .bus_addr, .bus_data, .stall,
        .bus_free, .bus_done, .got_kind, .got_addr, .got_data, .got_cnt);

    // clock at 50 MHz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // control register write by core or debug unit
    task automatic wctl(input logic core, input logic [11:0] idx, input logic [31:0] d);
        core_ctrl_wr = core;
        dbg_ctrl_wr = !core;
        ctrl_index = idx;
        ctrl_wdata = d;
        @(negedge clk);
        core_ctrl_wr = 1'b0;
        dbg_ctrl_wr = 1'b0;
    endtask
    // debug read, data registered one edge later
    task automatic rdctl(input logic [31:0] exp);
        dbg_ctrl_rd = 1'b1;
        ctrl_index = 12'h002;
        @(negedge clk);
        dbg_ctrl_rd = 1'b0;
        chk(dbg_ctrl_rdata, exp);
    endtask
    // one allocation per edge, alloc_req held by caller
    task automatic vic(input int i);
        set_valid = vv[i];
        #2;
        chk(32'(victim_way), 32'(ve[i]));
        @(negedge clk);
    endtask
    // wait for next finished bus cycle; lvl 0 kind, 1 addr, 2 data
    task automatic bus_exp(input cbd_pkg::cbd_bus_kind_t k, input logic [31:0] a,
        input logic [31:0] d, input int lvl);
        int c;
        c = got_cnt;
        for (int j = 0; j < 100 && got_cnt == c; j++) @(negedge clk);
        chk(32'(got_cnt != c), 32'h1);
        chk(32'(got_kind), 32'(k));
        if (lvl > 0) chk(got_addr, a);
        if (lvl > 1) chk(got_data, d);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run
    initial begin
        #100us;
        miscompares++;
        complete_run();
    end

    initial begin
        {core_ctrl_wr, dbg_ctrl_wr, dbg_ctrl_rd, wr_req, wr_imprecise, wr_inhibited} = '0;
        {fill_req, sync_req, push_load, alloc_req, hit_write, hit_copyback} = '0;
        {line_push_instr, line_modified, set_valid, ctrl_index, ctrl_wdata} = '0;
        {wr_addr, wr_data, push_addr} = '0;
        stall = 1'b1;
        rst_n = 1'b0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        chk(32'({cache_on, store_buf_on, push_keeps_valid, half_lock}), 32'h0);
        rdctl(32'h00000000);
        alloc_req = 1'b1;
        wr_req = 1'b1;
        wr_imprecise = 1'b1;
        #2;
        chk(32'(alloc_ok), 32'h0);
        chk(32'(wr_stall), 32'h1);
        @(negedge clk);
        wr_req = 1'b0;
        $display("end of test: reset");
        wctl(1'b1, 12'h002, 32'hB0000600);
        chk(32'({cache_on, store_buf_on, push_keeps_valid, half_lock}), 32'hE);
        rdctl(32'hB0000000);
        wctl(1'b0, 12'h003, 32'h00000000);
        rdctl(32'hB0000000);
        {line_push_instr, line_modified} = 2'b11;
        #2;
        chk(32'({push_writeback, push_invalidate}), 32'h2);
        $display("end of test: control register");
        @(negedge clk);
        wctl(1'b0, 12'h002, 32'h81000000);
        chk(32'({inv_busy, inv_clear, inv_set}), 32'h180);
        line_modified = 1'b0;
        #2;
        chk(32'({push_writeback, push_invalidate}), 32'h1);
        chk(32'(alloc_ok), 32'h0);
        n = 0;
        while (inv_busy === 1'b1 && n < 300) begin
            last = inv_set;
            n++;
            @(negedge clk);
        end
        chk(32'(n), 32'd128);
        chk(32'(last), 32'h7F);
        rdctl(32'h80000000);
        $display("end of test: invalidate all");
        chk(32'(alloc_ok), 32'h1);
        for (int i = 0; i < 10; i++) vic(i);
        set_valid = 4'h0;
        wctl(1'b1, 12'h002, 32'h88000000);
        chk(32'(half_lock), 32'h1);
        for (int i = 10; i < 17; i++) vic(i);
        alloc_req = 1'b0;
        {hit_write, hit_copyback} = 2'b11;
        #2;
        chk(32'(set_modified), 32'h1);
        @(negedge clk);
        hit_copyback = 1'b0;
        #2;
        chk(32'(set_modified), 32'h0);
        $display("end of test: allocation");
        wctl(1'b1, 12'h002, 32'hA0000000);
        push_load = 1'b1;
        push_addr = 32'h00001000;
        wr_req = 1'b1;
        wr_imprecise = 1'b0;
        wr_inhibited = 1'b1;
        #2;
        chk(32'(wr_stall), 32'h1);
        @(negedge clk);
        push_load = 1'b0;
        wr_imprecise = 1'b1;
        chk(32'(push_busy), 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr_addr = 32'h100 + 32'(i * 4);
            wr_data = 32'hD0 + 32'(i);
            #2;
            chk(32'(wr_stall), 32'h0);
            @(negedge clk);
        end
        #2;
        chk(32'(wr_stall), 32'h1);
        @(negedge clk);
        wr_req = 1'b0;
        {sync_req, fill_req} = 2'b11;
        #2;
        chk(32'({sync_stall, fill_stall}), 32'h3);
        @(negedge clk);
        stall = 1'b0;
        bus_exp(cbd_pkg::BUS_PUSH, 32'h00001000, 32'h0, 1);
        for (int i = 0; i < 4; i++) bus_exp(cbd_pkg::BUS_STORE, 32'h100 + 32'(i * 4),
            32'hD0 + 32'(i), 2);
        chk(32'({push_busy, sync_stall, fill_stall}), 32'h0);
        bus_exp(cbd_pkg::BUS_FILL, 32'h0, 32'h0, 0);
        {sync_req, fill_req} = 2'b00;
        $display("end of test: buffer drain");
        complete_run();
    end
endmodule // tb_top
